// *** bench/chgaux_regs_asserts.sv ***
// concurrent checks on the charger auxiliary register bank ports
`timescale 1ns/1ps
module chgaux_regs_asserts
#(
  parameter int CLK_MHZ = 100
)
(
  // clock and resets
  input wire logic                     mclk,
  input wire logic                     rst,
  input wire logic                     clkEn,
  input wire logic                     coreDigitalReset,
  // register port
  input wire logic                     regWrite,
  input wire logic [7:0]               regAddr,
  input wire logic [7:0]               regWdata,
  input wire logic [7:0]               regRdata,
  // status and decoded outputs
  input wire chgaux_pkg::chgaux_mode_t chargerMode,
  input wire logic                     endOfChargeCurrent,
  input wire chgaux_pkg::chgaux_cfg_t  cfg,
  input wire logic [23:0]              overvoltageDebounceCycles,
  input wire logic [23:0]              wakeupDelayCycles,
  input wire logic                     overvoltageCodeReserved,
  input wire logic                     modeIntPulse,
  input wire logic                     eocIntPulse
);
  import chgaux_pkg::*;
  // either reset silences all checks
  default clocking @(posedge mclk); endclocking
  default disable iff (rst || coreDigitalReset);
  phy_write_a: assert property (regWrite && clkEn && regAddr == 8'h16 |=>
    cfg.phySupplyHigh == $past(regWdata[1]) && cfg.regulatorOn == $past(regWdata[2])) else $error("phy write");
  discharge_gate_a: assert property (regAddr == 8'h16 |->
    cfg.dischargeOn == (regRdata[0] && !regRdata[2])) else $error("discharge gate");
  temp_write_a: assert property (regWrite && clkEn && regAddr == 8'h1A |=>
    {cfg.currentScale, cfg.voltageReduction, cfg.coolLow, cfg.warmHigh} == $past(regWdata[5:0])) else $error("temp");
  wake_write_a: assert property (regWrite && clkEn && regAddr == 8'h18 |=>
    cfg.wakeupCode == $past(regWdata[5:4]) && cfg.overvoltageCode == $past(regWdata[1:0])) else $error("wake");
  debounce_count_a: assert property (overvoltageDebounceCycles == 24'(CLK_MHZ *
    (cfg.overvoltageCode == 2'h0 ? 10 : cfg.overvoltageCode == 2'h1 ? 100 : cfg.overvoltageCode == 2'h2 ? 1000 : 10000))
    && overvoltageCodeReserved == (cfg.overvoltageCode == 2'h0)) else $error("debounce count");
  wake_count_a: assert property (wakeupDelayCycles == 24'(CLK_MHZ *
    (cfg.wakeupCode == 2'h0 ? 8000 : cfg.wakeupCode == 2'h1 ? 16000 : cfg.wakeupCode == 2'h2 ? 32000 : 100000)))
    else $error("wake count");
  fast_cv_a: assert property (clkEn && $past(clkEn) && chargerMode == CHGAUX_MODE_CV
    && $past(chargerMode) == CHGAUX_MODE_FAST |=> modeIntPulse) else $error("fast to cv");
  mode_cause_a: assert property (modeIntPulse |-> $past(chargerMode, 2) != $past(chargerMode))
    else $error("mode pulse cause");
  eoc_edge_a: assert property (eocIntPulse |-> $past(endOfChargeCurrent) && !$past(endOfChargeCurrent, 2))
    else $error("eoc pulse cause");
  freeze_a: assert property (!clkEn |=> $stable(cfg) && !modeIntPulse && !eocIntPulse)
    else $error("freeze");
endmodule
bind chgaux_regs chgaux_regs_asserts #(.CLK_MHZ(CLK_MHZ)) u_chk (.mclk, .rst, .clkEn, .coreDigitalReset,
  .regWrite, .regAddr, .regWdata, .regRdata, .chargerMode, .endOfChargeCurrent, .cfg,
  .overvoltageDebounceCycles, .wakeupDelayCycles, .overvoltageCodeReserved, .modeIntPulse, .eocIntPulse);

// *** bench/test_chgaux_regs.sv ***
// self-checking bench for the charger auxiliary register bank
`timescale 1ns/1ps
module test_chgaux_regs;
  import chgaux_pkg::*;
  // stimulus, outputs and expectation state
  logic         mclk = 0, rst = 1, clkEn = 1, coreDigitalReset = 0, regWrite = 0, endOfChargeCurrent = 0;
  logic [7:0]   regAddr = 8'h00, regWdata = 8'h00, regRdata, d, regModel[4];
  logic [23:0]  ovCycles, wakeCycles;
  logic         ovReserved, modeIntPulse, eocIntPulse;
  chgaux_cfg_t  cfg;
  chgaux_mode_t chargerMode = CHGAUX_MODE_NONE;
  chgaux_mode_t lastMode = CHGAUX_MODE_NONE;
  int           fail_count = 0, comparisons = 0;
  logic [7:0]   adr[4] = '{CHGAUX_PHY_SUPPLY_CONFIG_ADDR, CHGAUX_DEBOUNCE_DELAY_ADDR,
                           CHGAUX_CHARGER_INT_CONFIG_ADDR, CHGAUX_TEMPERATURE_ADJUST_ADDR};
  chgaux_mode_t walk[9] = '{CHGAUX_MODE_FAST, CHGAUX_MODE_CV, CHGAUX_MODE_EOC, CHGAUX_MODE_DONE,
                            CHGAUX_MODE_NONE, CHGAUX_MODE_CV, CHGAUX_MODE_FAST, CHGAUX_MODE_CV, CHGAUX_MODE_CV};
  // 100 MHz clock
  always #5 mclk = ~mclk;
  chgaux_regs u_dut (.mclk(mclk), .rst(rst), .clkEn(clkEn), .coreDigitalReset(coreDigitalReset),
    .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .chargerMode(chargerMode), .endOfChargeCurrent(endOfChargeCurrent), .cfg(cfg),
    .overvoltageDebounceCycles(ovCycles), .wakeupDelayCycles(wakeCycles),
    .overvoltageCodeReserved(ovReserved), .modeIntPulse(modeIntPulse), .eocIntPulse(eocIntPulse));
  // tick returns 1 ns after the edge; chkAll then steps regAddr a further 1 ns per read
  task tick;
    @(posedge mclk);
    #1;
  endtask
  task chk(string nm, logic [23:0] seen, logic [23:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("Error %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask
  // strobe drops for a cycle so back-to-back calls never collide
  task wr(logic [7:0] a, logic [7:0] v);
    regWrite = 1;
    regAddr  = a;
    regWdata = v;
    tick;
    regWrite = 0;
    tick;
  endtask
  task chkAll;
    for (int i = 0; i < 4; i++)
    begin
      regAddr = adr[i];
      #1 chk("regRdata", regRdata, regModel[i]);
    end
    regAddr = 8'h17;
    #1 chk("unmapped", regRdata, 8'h00);
    chk("dischargeOn", cfg.dischargeOn, regModel[0][0] & ~regModel[0][2]);
    chk("phySupplyHigh", cfg.phySupplyHigh, regModel[0][1]);
    chk("regulatorOn", cfg.regulatorOn, regModel[0][2]);
    chk("ovCycles", ovCycles, expOv(regModel[1][1:0]));
    chk("ovReserved", ovReserved, regModel[1][1:0] == 2'd0);
    chk("wakeCycles", wakeCycles, expWake(regModel[1][5:4]));
    chk("warmHigh", cfg.warmHigh, regModel[3][0]);
    chk("coolLow", cfg.coolLow, regModel[3][1]);
    chk("voltageReduction", cfg.voltageReduction, regModel[3][3:2]);
    chk("currentScale", cfg.currentScale, regModel[3][5:4]);
  endtask
  // debounce and wake-up lengths in cycles from the package timing table
  function logic [23:0] expOv(logic [1:0] c);
    return 24'(CHGAUX_CLK_MHZ * (c == 2'd0 ? CHGAUX_OVDB_CODE0_US : c == 2'd1 ? CHGAUX_OVDB_CODE1_US :
      c == 2'd2 ? CHGAUX_OVDB_CODE2_US : CHGAUX_OVDB_CODE3_US));
  endfunction
  function logic [23:0] expWake(logic [1:0] c);
    return 24'(CHGAUX_CLK_MHZ * 1000 * (c == 2'd0 ? CHGAUX_WAKE_CODE0_MS : c == 2'd1 ? CHGAUX_WAKE_CODE1_MS :
      c == 2'd2 ? CHGAUX_WAKE_CODE2_MS : CHGAUX_WAKE_CODE3_MS));
  endfunction
  function logic expInt(logic s, chgaux_mode_t p, chgaux_mode_t c);
    return (p != c) && (s || (p == CHGAUX_MODE_FAST && c == CHGAUX_MODE_CV));
  endfunction
  task mode(chgaux_mode_t m, logic s);
    chargerMode = m;
    tick;
    chk("modeIntPulse", modeIntPulse, expInt(s, lastMode, m));
    lastMode = m;
  endtask
  task report_and_stop;
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    d = 8'($urandom(32'hee91_7bb2));
    repeat (6) tick;
    rst = 0;
    regModel = '{8'h01, 8'h00, 8'h00, 8'h00};
    chkAll();
    repeat (24)
    begin
      d = 8'($urandom);
      regModel[$urandom_range(3)] = d;
      foreach (regModel[i]) if (regModel[i] === d) wr(adr[i], d);
      chkAll();
    end
    wr(8'h17, 8'hff);
    clkEn = 0;
    wr(adr[0], ~regModel[0]);
    clkEn = 1;
    chkAll();
    coreDigitalReset = 1;
    tick;
    coreDigitalReset = 0;
    regModel = '{8'h01, 8'h00, 8'h00, 8'h00};
    chkAll();
    for (int s = 0; s < 2; s++)
    begin
      wr(adr[2], {6'h00, s[0], s[0]});
      foreach (walk[i]) mode(walk[i], s[0]);
      repeat (6) mode(chgaux_mode_t'($urandom_range(4)), s[0]);
      endOfChargeCurrent = 1;
      tick;
      chk("eocIntPulse", eocIntPulse, s[0]);
      tick;
      chk("eocIntPulse held", eocIntPulse, 8'h00);
      endOfChargeCurrent = 0;
    end
    report_and_stop();
  end
endmodule

// *** pkg/chgaux_pkg.sv ***
// package for the charger auxiliary configuration register bank
// Behaviour
// - discharge bit discharges supply while regulator off
// - voltage select: 0 is 3.3 V, 1 is 4.9 V
// - debounce field codes 100us/1ms/10ms, zero reserved
// - select 0: interrupt only fast-charge to CV
// - select 1: interrupt on every mode change
// - end-of-charge bit gates end-of-charge interrupt
// - warm threshold 0 is 45C, 1 is 50C
// - cool threshold 0 is 15C, 1 is 10C
// - voltage reduction codes 60/100/160/200 mV
// - current scale codes 25/50/75/100 percent
// - core reset restores defaults, spare bits store
package chgaux_pkg;

  // register offsets
  localparam logic [7:0] CHGAUX_PHY_SUPPLY_CONFIG_ADDR   = 8'h16;
  localparam logic [7:0] CHGAUX_DEBOUNCE_DELAY_ADDR      = 8'h18;
  localparam logic [7:0] CHGAUX_CHARGER_INT_CONFIG_ADDR  = 8'h19;
  localparam logic [7:0] CHGAUX_TEMPERATURE_ADJUST_ADDR  = 8'h1A;

  // reset values
  localparam logic [7:0] CHGAUX_PHY_SUPPLY_RESET   = 8'h01;
  localparam logic [7:0] CHGAUX_DEBOUNCE_RESET     = 8'h00;
  localparam logic [7:0] CHGAUX_CHARGER_INT_RESET  = 8'h00;
  localparam logic [7:0] CHGAUX_TEMPERATURE_RESET  = 8'h00;

  // field positions
  localparam int CHGAUX_DISCHARGE_BIT   = 0;
  localparam int CHGAUX_VSEL_BIT        = 1;
  localparam int CHGAUX_REG_ON_BIT      = 2;
  localparam int CHGAUX_OVDB_LSB        = 0;
  localparam int CHGAUX_PHYDB_LSB       = 2;
  localparam int CHGAUX_WAKE_LSB        = 4;
  localparam int CHGAUX_TRANS_SEL_BIT   = 0;
  localparam int CHGAUX_EOC_INT_BIT     = 1;
  localparam int CHGAUX_WARM_BIT        = 0;
  localparam int CHGAUX_COOL_BIT        = 1;
  localparam int CHGAUX_VRED_LSB        = 2;
  localparam int CHGAUX_ISCALE_LSB      = 4;

  // debounce timings in microseconds per code
  localparam int CHGAUX_OVDB_CODE0_US   = 10;
  localparam int CHGAUX_OVDB_CODE1_US   = 100;
  localparam int CHGAUX_OVDB_CODE2_US   = 1000;
  localparam int CHGAUX_OVDB_CODE3_US   = 10000;
  // wake-up timings in milliseconds per code
  localparam int CHGAUX_WAKE_CODE0_MS   = 8;
  localparam int CHGAUX_WAKE_CODE1_MS   = 16;
  localparam int CHGAUX_WAKE_CODE2_MS   = 32;
  localparam int CHGAUX_WAKE_CODE3_MS   = 100;
  // clock rate and derived cycles per microsecond
  localparam int CHGAUX_CLK_MHZ         = 100;

  // charger modes as reported by the charger core
  typedef enum logic [2:0] {
    CHGAUX_MODE_NONE = 3'b000,
    CHGAUX_MODE_FAST = 3'b001,
    CHGAUX_MODE_CV   = 3'b010,
    CHGAUX_MODE_EOC  = 3'b011,
    CHGAUX_MODE_DONE = 3'b100
  } chgaux_mode_t;

  // decoded settings handed to the analog and charger logic
  typedef struct packed {
    logic        dischargeOn;      // active discharge pulldown on
    logic        phySupplyHigh;    // 1 selects 4.9 V, 0 selects 3.3 V
    logic        regulatorOn;
    logic [1:0]  overvoltageCode;
    logic [1:0]  phyDebounceCode;  // stored, unused by the device
    logic [1:0]  wakeupCode;
    logic        warmHigh;         // 1 selects 50 C
    logic        coolLow;          // 1 selects 10 C
    logic [1:0]  voltageReduction;
    logic [1:0]  currentScale;
  } chgaux_cfg_t;

endpackage

// *** rtl/chgaux_regs.sv ***
// charger auxiliary configuration registers with decode and event logic
`timescale 1ns/1ps
module chgaux_regs
#(
  parameter int CLK_MHZ = 100
)
(
  // clock and reset
  input  wire logic                         mclk,
  input  wire logic                         rst,
  input  wire logic                         clkEn,
  input  wire logic                         coreDigitalReset,
  // register port from the serial control interface
  input  wire logic                         regWrite,
  input  wire logic [7:0]                   regAddr,
  input  wire logic [7:0]                   regWdata,
  output logic      [7:0]                   regRdata,
  // charger status
  input  wire chgaux_pkg::chgaux_mode_t     chargerMode,
  input  wire logic                         endOfChargeCurrent,
  // decoded settings
  output chgaux_pkg::chgaux_cfg_t           cfg,
  output logic      [23:0]                  overvoltageDebounceCycles,
  output logic      [23:0]                  wakeupDelayCycles,
  output logic                              overvoltageCodeReserved,
  // charger events, one cycle each
  output logic                              modeIntPulse,
  output logic                              eocIntPulse
);
  import chgaux_pkg::*;

  logic [7:0]   phyCfg_q;
  logic [7:0]   dbncCfg_q;
  logic [7:0]   intCfg_q;
  logic [7:0]   tempCfg_q;
  chgaux_mode_t modePrev_q;
  logic         eocPrev_q;
  logic         clear;

  assign clear = rst | coreDigitalReset;

  // phy supply register, discharge default on
  // core reset defaults
  always_ff @(posedge mclk)
  begin
    if (clear)
      phyCfg_q <= CHGAUX_PHY_SUPPLY_RESET;
    else if (clkEn && regWrite && regAddr == CHGAUX_PHY_SUPPLY_CONFIG_ADDR)
      phyCfg_q <= regWdata;
  end

  // debounce and wake-up register
  always_ff @(posedge mclk)
  begin
    if (clear)
      dbncCfg_q <= CHGAUX_DEBOUNCE_RESET;
    else if (clkEn && regWrite && regAddr == CHGAUX_DEBOUNCE_DELAY_ADDR)
      dbncCfg_q <= regWdata;
  end

  // interrupt configuration register
  always_ff @(posedge mclk)
  begin
    if (clear)
      intCfg_q <= CHGAUX_CHARGER_INT_RESET;
    else if (clkEn && regWrite && regAddr == CHGAUX_CHARGER_INT_CONFIG_ADDR)
      intCfg_q <= regWdata;
  end

  // temperature adjust register
  always_ff @(posedge mclk)
  begin
    if (clear)
      tempCfg_q <= CHGAUX_TEMPERATURE_RESET;
    else if (clkEn && regWrite && regAddr == CHGAUX_TEMPERATURE_ADJUST_ADDR)
      tempCfg_q <= regWdata;
  end

  // readback, unmapped addresses read zero
  always_comb
  begin
    unique case (regAddr)
      CHGAUX_PHY_SUPPLY_CONFIG_ADDR:  regRdata = phyCfg_q;
      CHGAUX_DEBOUNCE_DELAY_ADDR:     regRdata = dbncCfg_q;
      CHGAUX_CHARGER_INT_CONFIG_ADDR: regRdata = intCfg_q;
      CHGAUX_TEMPERATURE_ADJUST_ADDR: regRdata = tempCfg_q;
      default:                        regRdata = 8'h00;
    endcase
  end

  // decoded supply, debounce, wake-up and temperature controls
  always_comb
  begin
    cfg                  = '0;
    cfg.regulatorOn      = phyCfg_q[CHGAUX_REG_ON_BIT];
    cfg.dischargeOn      = phyCfg_q[CHGAUX_DISCHARGE_BIT] & ~phyCfg_q[CHGAUX_REG_ON_BIT];
    cfg.phySupplyHigh    = phyCfg_q[CHGAUX_VSEL_BIT];
    cfg.overvoltageCode  = dbncCfg_q[CHGAUX_OVDB_LSB +: 2];
    cfg.phyDebounceCode  = dbncCfg_q[CHGAUX_PHYDB_LSB +: 2];
    cfg.wakeupCode       = dbncCfg_q[CHGAUX_WAKE_LSB +: 2];
    cfg.warmHigh         = tempCfg_q[CHGAUX_WARM_BIT];
    cfg.coolLow          = tempCfg_q[CHGAUX_COOL_BIT];
    cfg.voltageReduction = tempCfg_q[CHGAUX_VRED_LSB +: 2];
    cfg.currentScale     = tempCfg_q[CHGAUX_ISCALE_LSB +: 2];
  end

  // timer lengths in mclk cycles for the overvoltage debouncer and the wake-up delay
  always_comb
  begin
    unique case (dbncCfg_q[CHGAUX_OVDB_LSB +: 2])
      2'd0:    overvoltageDebounceCycles = 24'(CHGAUX_OVDB_CODE0_US * CLK_MHZ);
      2'd1:    overvoltageDebounceCycles = 24'(CHGAUX_OVDB_CODE1_US * CLK_MHZ);
      2'd2:    overvoltageDebounceCycles = 24'(CHGAUX_OVDB_CODE2_US * CLK_MHZ);
      default: overvoltageDebounceCycles = 24'(CHGAUX_OVDB_CODE3_US * CLK_MHZ);
    endcase
    unique case (dbncCfg_q[CHGAUX_WAKE_LSB +: 2])
      2'd0:    wakeupDelayCycles = 24'(CHGAUX_WAKE_CODE0_MS * 1000 * CLK_MHZ);
      2'd1:    wakeupDelayCycles = 24'(CHGAUX_WAKE_CODE1_MS * 1000 * CLK_MHZ);
      2'd2:    wakeupDelayCycles = 24'(CHGAUX_WAKE_CODE2_MS * 1000 * CLK_MHZ);
      default: wakeupDelayCycles = 24'(CHGAUX_WAKE_CODE3_MS * 1000 * CLK_MHZ);
    endcase
  end

  // code zero still runs, but software is warned it is reserved
  // flag reserved code
  assign overvoltageCodeReserved = (dbncCfg_q[CHGAUX_OVDB_LSB +: 2] == 2'd0);

  // previous charger status for edge detection
  always_ff @(posedge mclk)
  begin
    if (clear)
    begin
      modePrev_q <= CHGAUX_MODE_NONE;
      eocPrev_q  <= 1'b0;
    end
    else if (clkEn)
    begin
      modePrev_q <= chargerMode;
      eocPrev_q  <= endOfChargeCurrent;
    end
  end

  // mode-change interrupt pulse
  always_ff @(posedge mclk)
  begin
    if (clear)
      modeIntPulse <= 1'b0;
    else if (clkEn)
    begin
      if (intCfg_q[CHGAUX_TRANS_SEL_BIT])
        modeIntPulse <= (chargerMode != modePrev_q);
      else
        modeIntPulse <= (modePrev_q == CHGAUX_MODE_FAST) && (chargerMode == CHGAUX_MODE_CV);
    end
    else
      modeIntPulse <= 1'b0;
  end

  // end-of-charge interrupt pulse on rising current trigger
  always_ff @(posedge mclk)
  begin
    if (clear)
      eocIntPulse <= 1'b0;
    else if (clkEn)
      eocIntPulse <= intCfg_q[CHGAUX_EOC_INT_BIT] & endOfChargeCurrent & ~eocPrev_q;
    else
      eocIntPulse <= 1'b0;
  end

endmodule
